// *** shared/buck_ctrl_pkg.sv ***
// Package with register map, field layout and codes of the buck control block.
package buck_ctrl_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [9:0] buck2_control_off = 10'h020;
    localparam logic [9:0] buck1_control_off = 10'h021;
    localparam logic [9:0] buck4_control_off = 10'h022;
    localparam logic [9:0] buck3_control_off = 10'h024;
    // ************************************************************
    // Field positions and reset value
    // ************************************************************
    localparam int on_request_bit = 0;
    localparam int enable_sel_lsb = 1;
    localparam int sequenced_cfg_bit = 3;
    localparam int voltage_sel_lsb = 5;
    localparam logic [7:0] writable_mask = 8'h6f;
    localparam logic [7:0] control_reset = 8'h00;
    localparam int debounce_cycles = 4;
    // ************************************************************
    // Source selector codes
    // ************************************************************
    typedef enum logic [1:0] {
        src_sequencer = 2'h0,
        src_input_one = 2'h1,
        src_input_two = 2'h2,
        src_input_three = 2'h3
    } source_sel_e;
endpackage : buck_ctrl_pkg

// *** verilog/input_conditioner.sv ***
// Synchroniser, polarity correction, debounce and edge detection of one input.
`timescale 1ns/10ps
module input_conditioner #(
    parameter int debounce_len = buck_ctrl_pkg::debounce_cycles
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin_raw,
    input wire logic active_high,
    input wire logic debounce_on,
    output logic level_active,
    output logic rise_pulse,
    output logic fall_pulse
);
    logic sync1_q, sync2_q;
    logic [3:0] stable_cnt_q, stable_cnt_d;
    logic level_q, level_d;
    logic [1:0] fill_q, fill_d;
    logic corrected;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // Polarity correction keeps the active level as logic one.
    assign corrected = active_high ? sync2_q : ~sync2_q;

    // The synchroniser holds zero until two edges after reset, which an
    // active-low input would read as active, so the level waits for it.
    always_comb begin
        fill_d = {fill_q[0], 1'b1};
        stable_cnt_d = '0;
        level_d = level_q;
        if (!fill_q[1] || corrected == level_q) begin
            stable_cnt_d = '0;
        end else if (!debounce_on ||
                     stable_cnt_q == 4'(debounce_len - 1)) begin
            level_d = corrected;
        end else begin
            stable_cnt_d = stable_cnt_q + 4'h1;
        end
    end

    // A polarity change at reset release would otherwise fake an edge, so
    // the level starts passive and any real edge is taken afterwards.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_cnt_q <= '0;
            level_q <= 1'b0;
            fill_q <= 2'h0;
        end else begin
            stable_cnt_q <= stable_cnt_d;
            level_q <= level_d;
            fill_q <= fill_d;
        end
    end

    assign level_active = level_q;
    assign rise_pulse = level_d & ~level_q;
    assign fall_pulse = ~level_d & level_q;

    chk_single_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rise_pulse |=> !rise_pulse) else $error("double rise pulse");
    chk_no_early_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !fill_q[1] |-> (!rise_pulse && !fall_pulse))
        else $error("edge before synchroniser filled");
endmodule : input_conditioner

// *** verilog/buck_supply_control_regs.sv ***
// Control registers of the four buck converters with input-driven control.
`timescale 1ns/10ps
module buck_supply_control_regs (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [9:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic general_input_one,
    input wire logic general_input_two,
    input wire logic general_input_three,
    input wire logic [2:0] input_polarity,
    input wire logic [2:0] input_debounce,
    input wire logic dual_phase_mode,
    input wire logic [3:0] sequencer_enable,
    input wire logic [3:0] sequencer_voltage_a,
    output logic [3:0] conv_enable,
    output logic [3:0] conv_voltage_a,
    output logic [3:0] conv_sequenced_cfg
);
    // ************************************************************
    // Input conditioning
    // ************************************************************
    logic [2:0] pins, rise, fall;
    assign pins = {general_input_three, general_input_two, general_input_one};

    for (genvar g = 0; g < 3; g++) begin : gen_inp
        input_conditioner u_cond (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .pin_raw(pins[g]),
            .active_high(input_polarity[g]),
            .debounce_on(input_debounce[g]),
            .level_active(),
            .rise_pulse(rise[g]),
            .fall_pulse(fall[g])
        );
    end

    // ************************************************************
    // Register file, index 0..3 is buck one to four
    // ************************************************************
    logic [7:0] ctrl_q [4];
    logic [7:0] ctrl_d [4];

    function automatic logic [2:0] reg_index(input logic [9:0] a);
        if (a == buck_ctrl_pkg::buck1_control_off) reg_index = 3'h4;
        else if (a == buck_ctrl_pkg::buck2_control_off) reg_index = 3'h5;
        else if (a == buck_ctrl_pkg::buck3_control_off) reg_index = 3'h6;
        else if (a == buck_ctrl_pkg::buck4_control_off) reg_index = 3'h7;
        else reg_index = 3'h0;
    endfunction : reg_index

    logic [2:0] hit;
    assign hit = reg_index(reg_addr);

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ctrl_d[i] = ctrl_q[i];
            if (reg_wr && hit == 3'(4 + i)) begin
                // Reserved bits 7 and 4 are kept at zero.
                ctrl_d[i] = reg_wdata & buck_ctrl_pkg::writable_mask;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                ctrl_q[i] <= buck_ctrl_pkg::control_reset;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                ctrl_q[i] <= ctrl_d[i];
            end
        end
    end

    always_comb begin
        reg_rdata = 8'h00;
        if (hit[2]) begin
            reg_rdata = ctrl_q[hit[1:0]];
        end
    end

    // ************************************************************
    // Source selection and converter state
    // ************************************************************
    function automatic logic pick(input logic [1:0] sel,
                                  input logic [2:0] v);
        pick = (sel == 2'h0) ? 1'b0 : v[sel - 2'h1];
    endfunction : pick

    logic [3:0] en_q, en_d, va_q, va_d;

    always_comb begin
        logic [1:0] es, vs;
        es = 2'h0;
        vs = 2'h0;
        for (int i = 0; i < 4; i++) begin
            es = ctrl_q[i][buck_ctrl_pkg::enable_sel_lsb +: 2];
            vs = ctrl_q[i][buck_ctrl_pkg::voltage_sel_lsb +: 2];
            en_d[i] = en_q[i];
            va_d[i] = va_q[i];
            if (es == buck_ctrl_pkg::src_sequencer) begin
                en_d[i] = sequencer_enable[i] &
                          ctrl_q[i][buck_ctrl_pkg::on_request_bit];
            end else if (pick(es, rise)) begin
                en_d[i] = 1'b1;
            end else if (pick(es, fall)) begin
                en_d[i] = 1'b0;
            end
            if (vs == buck_ctrl_pkg::src_sequencer) begin
                va_d[i] = sequencer_voltage_a[i];
            end else if (pick(vs, rise)) begin
                va_d[i] = 1'b1;
            end else if (pick(vs, fall)) begin
                va_d[i] = 1'b0;
            end
        end
        // The enable of the second buck follows the first while both share the load.
        if (dual_phase_mode) begin
            en_d[1] = en_d[0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 4'h0;
            va_q <= 4'h0;
        end else begin
            en_q <= en_d;
            va_q <= va_d;
        end
    end

    assign conv_enable = en_q;
    assign conv_voltage_a = va_q;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            conv_sequenced_cfg[i] =
                ctrl_q[i][buck_ctrl_pkg::sequenced_cfg_bit];
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_dual_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dual_phase_mode |=> conv_enable[1] == conv_enable[0])
        else $error("second buck left first in dual phase");
    chk_gpi_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrl_q[2][2:1] == 2'h1 && rise[0]) |=> conv_enable[2])
        else $error("input rise did not enable buck three");
    chk_gpi_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrl_q[2][2:1] == 2'h1 && fall[0] && !rise[0]) |=> !conv_enable[2])
        else $error("input fall did not disable buck three");
    chk_volt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrl_q[3][6:5] == 2'h2 && rise[1]) |=> conv_voltage_a[3])
        else $error("input rise did not pick setting a");
    chk_volt_b: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrl_q[3][6:5] == 2'h3 && fall[2]) |=> !conv_voltage_a[3])
        else $error("input fall did not pick setting b");
    chk_seq_volt: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrl_q[3][6:5] == 2'h0) |=>
        conv_voltage_a[3] == $past(sequencer_voltage_a[3]))
        else $error("buck four voltage left the sequencer");
    chk_dual_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (dual_phase_mode && ctrl_q[0][2:0] == 3'h0) |=> !conv_enable[1])
        else $error("second buck own bit acted in dual phase");
    chk_seq_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrl_q[3][2:1] == 2'h0 && !ctrl_q[3][0] && !dual_phase_mode)
        |=> !conv_enable[3])
        else $error("buck four on without request");
    chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_rdata[7] == 1'b0 && reg_rdata[4] == 1'b0))
        else $error("reserved bit read as one");
    chk_write_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == buck_ctrl_pkg::buck3_control_off) ##1
        (!reg_wr && reg_addr == buck_ctrl_pkg::buck3_control_off)
        |-> reg_rdata == ($past(reg_wdata, 1) & buck_ctrl_pkg::writable_mask))
        else $error("buck three register readback wrong");
    chk_cfg_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == buck_ctrl_pkg::buck1_control_off) |=>
        conv_sequenced_cfg[0] ==
        $past(reg_wdata[3]))
        else $error("sequenced flag not taken");
endmodule : buck_supply_control_regs

// *** bench/gpi_source_model.sv ***
// Behavioural system logic that drives the three general inputs.
`timescale 1ns/10ps
module gpi_source_model (
    input wire logic sys_clk,
    input wire logic [2:0] level_req,
    output logic general_input_one,
    output logic general_input_two,
    output logic general_input_three
);
    // Pins move on the falling edge so they never race the sampling edge.
    initial begin
        general_input_one = 1'b0;
        general_input_two = 1'b0;
        general_input_three = 1'b0;
    end
    always @(negedge sys_clk) begin
        general_input_one <= level_req[0];
        general_input_two <= level_req[1];
        general_input_three <= level_req[2];
    end
endmodule : gpi_source_model

// *** bench/test_buck_supply_control_regs.sv ***
// Self-checking testbench of the buck control registers.
`timescale 1ns/10ps
module test_buck_supply_control_regs;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic gi1, gi2, gi3;
    logic [2:0] level_req = 3'h0;
    logic [2:0] pol = 3'h7;
    logic [2:0] deb = 3'h0;
    logic dual = 1'b0;
    logic [3:0] seq_en = 4'h0;
    logic [3:0] seq_va = 4'h0;
    logic [3:0] conv_en, conv_va, conv_cfg;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    localparam logic [9:0] b1 = buck_ctrl_pkg::buck1_control_off;
    localparam logic [9:0] b2 = buck_ctrl_pkg::buck2_control_off;
    localparam logic [9:0] b3 = buck_ctrl_pkg::buck3_control_off;
    localparam logic [9:0] b4 = buck_ctrl_pkg::buck4_control_off;

    always #50 sys_clk = ~sys_clk;

    gpi_source_model u_gpi (.sys_clk(sys_clk), .level_req(level_req),
        .general_input_one(gi1), .general_input_two(gi2),
        .general_input_three(gi3));
    buck_supply_control_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .general_input_one(gi1),
        .general_input_two(gi2), .general_input_three(gi3),
        .input_polarity(pol), .input_debounce(deb),
        .dual_phase_mode(dual), .sequencer_enable(seq_en),
        .sequencer_voltage_a(seq_va), .conv_enable(conv_en),
        .conv_voltage_a(conv_va), .conv_sequenced_cfg(conv_cfg));

    task automatic complete_run;
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check8

    task automatic settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : settle

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd_check(input logic [9:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        reg_addr = a;
        #1 check8(reg_rdata, exp);
    endtask : rd_check

    task automatic reg_map_scan;
        logic [9:0] offs [4] = '{b2, b1, b4, b3};
        foreach (offs[i]) begin
            rd_check(offs[i], buck_ctrl_pkg::control_reset);
            wr(offs[i], 8'hff);
            rd_check(offs[i], 8'h6f);
            wr(offs[i], 8'h00);
        end
        wr(10'h023, 8'hff);
        rd_check(10'h023, 8'h00);
    endtask : reg_map_scan

    task automatic seq_control;
        seq_en = 4'h1;
        seq_va = 4'h8;
        settle(2);
        check8({4'h0, conv_en}, 8'h00);
        check8({4'h0, conv_va}, 8'h08);
        wr(b1, 8'h01);
        settle(2);
        check8({4'h0, conv_en}, 8'h01);
        seq_en = 4'h0;
        seq_va = 4'h0;
        settle(2);
        check8({4'h0, conv_en}, 8'h00);
    endtask : seq_control

    task automatic input_walk(input logic voltage);
        for (int k = 1; k <= 3; k++) begin
            if (voltage) wr(b4, {1'b0, 2'(k), 5'h00});
            else wr(b3, {5'h00, 2'(k), 1'b0});
            level_req = 3'(1 << (k - 1));
            settle(12);
            check8({7'h00, voltage ? conv_va[3] : conv_en[2]}, 8'h01);
            level_req = 3'h0;
            settle(12);
            check8({7'h00, voltage ? conv_va[3] : conv_en[2]}, 8'h00);
        end
    endtask : input_walk

    // Debounced input one drives buck three: the switch must come late.
    task automatic debounce_hold;
        deb = 3'h7;
        wr(b3, 8'h02);
        level_req = 3'h1;
        settle(4);
        check8({7'h00, conv_en[2]}, 8'h00);
        settle(4);
        check8({7'h00, conv_en[2]}, 8'h01);
        level_req = 3'h0;
        settle(8);
        check8({7'h00, conv_en[2]}, 8'h00);
        deb = 3'h0;
    endtask : debounce_hold

    task automatic polarity_flip;
        wr(b3, 8'h02);
        level_req = 3'h1;
        settle(8);
        check8({7'h00, conv_en[2]}, 8'h01);
        pol = 3'h6;
        settle(8);
        check8({7'h00, conv_en[2]}, 8'h00);
        level_req = 3'h0;
        settle(8);
        check8({7'h00, conv_en[2]}, 8'h01);
        pol = 3'h7;
        settle(8);
    endtask : polarity_flip

    task automatic dual_phase;
        dual = 1'b1;
        seq_en = 4'hf;
        wr(b1, 8'h00);
        wr(b2, 8'h01);
        settle(3);
        check8({6'h00, conv_en[1:0]}, 8'h00);
        wr(b1, 8'h01);
        settle(3);
        check8({6'h00, conv_en[1:0]}, 8'h03);
        dual = 1'b0;
        wr(b1, 8'h00);
        settle(3);
        check8({6'h00, conv_en[1:0]}, 8'h02);
    endtask : dual_phase

    task automatic cfg_bits;
        wr(b4, 8'h08);
        wr(b2, 8'h08);
        settle(1);
        check8({4'h0, conv_cfg}, 8'h0a);
    endtask : cfg_bits

    // Ceiling well above the few hundred cycles the scenarios need.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        check8({4'h0, conv_en}, 8'h00);
        reg_map_scan();
        seq_control();
        input_walk(1'b0);
        deb = 3'h7;
        input_walk(1'b1);
        deb = 3'h0;
        debounce_hold();
        polarity_flip();
        dual_phase();
        cfg_bits();
        complete_run();
    end
endmodule : test_buck_supply_control_regs
